// *** hw/usdp_uart.sv ***
// uart shadow data port with axi4-lite register slave
`timescale 1ns/10ps
`include "usdp_map.svh"

// Overview of operation
// - sixteen word aliases reach receive and transmit data
// - read returns received byte in low bits
// - infrared mode receives from infrared input
// - fifo off: new byte overwrites, flags overrun
// - fifo on: read returns and pops head
// - full receive fifo drops new byte, overrun
// - write sends on serial or infrared output
// - fifo off: one write clears holding-empty
// - fifo off: further writes overwrite pending byte
// - fifo on: transmit fifo holds depth bytes
// - write to full transmit fifo is dropped
// - upper bits reserved, data resets to zero
module usdp_uart import usdp_pkg::*; #(
  parameter int DEPTH = `USDP_FIFO_DEPTH,
  parameter int CLKS_PER_BIT = `USDP_CLKS_PER_BIT
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [31:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [31:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic SIN,
  input wire logic SIR_IN,
  output logic SOUT,
  output logic SIR_OUT_N,
  output logic IRQ
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(CLKS_PER_BIT);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [CW-1:0] LAST = CW'(CLKS_PER_BIT - 1);
  localparam logic [CW-1:0] HALF = CW'(CLKS_PER_BIT / 2 - 1);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
    $error("DEPTH must be a power of two of at least 2");
  if (CLKS_PER_BIT < 2 || (1 << CW) != CLKS_PER_BIT)
    $error("CLKS_PER_BIT must be a power of two of at least 2");

  function automatic logic is_shadow(input logic [31:0] a);
    is_shadow = a >= `USDP_SHADOW_BASE && a <= `USDP_SHADOW_LAST
      && a[1:0] == 2'b00;
  endfunction

  // bus state
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [31:0] aw_addr_r, aw_addr_nxt, w_data_r, w_data_nxt;
  logic w_strb0_r, w_strb0_nxt, bvalid_r, bvalid_nxt;
  logic rvalid_r, rvalid_nxt, rd_shadow_r, rd_shadow_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  // control and status
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [2:0] imr_r, imr_nxt, isr_r, isr_nxt;
  logic oe_r, oe_nxt;
  // receiver
  usdp_state_type rx_state_r, rx_state_nxt;
  logic [CW-1:0] rx_cnt_r, rx_cnt_nxt;
  logic [2:0] rx_bit_r, rx_bit_nxt;
  logic [7:0] rx_shift_r, rx_shift_nxt;
  logic [7:0] rx_mem [DEPTH];
  logic [AW-1:0] rx_wp_r, rx_wp_nxt, rx_rp_r, rx_rp_nxt;
  logic [AW:0] rx_count_r, rx_count_nxt;
  // transmitter
  usdp_state_type tx_state_r, tx_state_nxt;
  logic [CW-1:0] tx_cnt_r, tx_cnt_nxt;
  logic [2:0] tx_bit_r, tx_bit_nxt;
  logic [7:0] tx_shift_r, tx_shift_nxt;
  logic tx_line_r, tx_line_nxt;
  logic [7:0] tx_mem [DEPTH];
  logic [AW-1:0] tx_wp_r, tx_wp_nxt, tx_rp_r, tx_rp_nxt;
  logic [AW:0] tx_count_r, tx_count_nxt;
  // strobes
  logic fifo_en, ir_mode, rx_in, do_write, rd_take, tx_wr, rx_pop;
  logic rx_arrive, rx_push, rx_over, tx_pop, tx_push, tx_over, tx_empty;
  logic [AW-1:0] rx_mem_idx, tx_mem_idx;
  logic [7:0] rx_head, tx_head;

  assign fifo_en = ctrl_r[`USDP_CTRL_FIFO_EN];
  assign ir_mode = ctrl_r[`USDP_CTRL_IR_MODE];
  assign rx_in = ir_mode ? SIR_IN : SIN;
  assign rx_head = rx_mem[rx_rp_r];
  assign tx_head = tx_mem[tx_rp_r];
  assign tx_empty = tx_count_r == '0;
  assign AWREADY = !aw_hold_r;
  assign WREADY = !w_hold_r;
  assign ARREADY = !rvalid_r;
  assign BVALID = bvalid_r;
  assign BRESP = bresp_r;
  assign RVALID = rvalid_r;
  assign RDATA = rdata_r;
  assign RRESP = rresp_r;
  assign SOUT = ir_mode ? 1'b1 : tx_line_r;
  assign SIR_OUT_N = ir_mode ? tx_line_r : 1'b1;
  assign IRQ = |(isr_r & imr_r);

  always_comb begin
    do_write = aw_hold_r && w_hold_r && !bvalid_r;
    rd_take = ARVALID && !rvalid_r;
    tx_wr = do_write && is_shadow(aw_addr_r) && w_strb0_r;
    rx_pop = rd_take && is_shadow(ARADDR) && rx_count_r != '0;
    // bus channels
    aw_hold_nxt = aw_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_hold_nxt = w_hold_r;
    w_data_nxt = w_data_r;
    w_strb0_nxt = w_strb0_r;
    if (AWVALID && !aw_hold_r) begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = AWADDR;
    end
    if (WVALID && !w_hold_r) begin
      w_hold_nxt = 1'b1;
      w_data_nxt = WDATA;
      w_strb0_nxt = WSTRB[0];
    end
    bvalid_nxt = bvalid_r && !BREADY;
    bresp_nxt = bresp_r;
    ctrl_nxt = ctrl_r;
    imr_nxt = imr_r;
    if (do_write) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = `USDP_RESP_OKAY;
      if (aw_addr_r == `USDP_CTRL_ADDR) begin
        if (w_strb0_r)
          ctrl_nxt = w_data_r[1:0];
      end else if (aw_addr_r == `USDP_IMR_ADDR) begin
        if (w_strb0_r)
          imr_nxt = w_data_r[2:0];
      end else if (!is_shadow(aw_addr_r) && aw_addr_r != `USDP_LINE_STAT_ADDR
          && aw_addr_r != `USDP_ISR_ADDR) begin
        bresp_nxt = `USDP_RESP_SLVERR;
      end
    end
    rvalid_nxt = rvalid_r && !RREADY;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    rd_shadow_nxt = rd_shadow_r;
    if (rd_take) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `USDP_RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      rd_shadow_nxt = is_shadow(ARADDR);
      if (is_shadow(ARADDR)) begin
        rdata_nxt[7:0] = rx_head;
      end else if (ARADDR == `USDP_CTRL_ADDR) begin
        rdata_nxt[1:0] = ctrl_r;
      end else if (ARADDR == `USDP_LINE_STAT_ADDR) begin
        rdata_nxt[`USDP_STAT_RX_READY] = rx_count_r != '0;
        rdata_nxt[`USDP_STAT_OVERRUN] = oe_r;
        rdata_nxt[`USDP_STAT_TX_EMPTY] = tx_empty;
      end else if (ARADDR == `USDP_ISR_ADDR) begin
        rdata_nxt[2:0] = isr_r;
      end else if (ARADDR == `USDP_IMR_ADDR) begin
        rdata_nxt[2:0] = imr_r;
      end else begin
        rresp_nxt = `USDP_RESP_SLVERR;
      end
    end
    // receiver: start bit checked at mid-bit, then one sample per bit
    rx_state_nxt = rx_state_r;
    rx_cnt_nxt = rx_cnt_r + 1'b1;
    rx_bit_nxt = rx_bit_r;
    rx_shift_nxt = rx_shift_r;
    rx_arrive = 1'b0;
    case (rx_state_r)
      USDP_IDLE: begin
        rx_cnt_nxt = '0;
        if (!rx_in)
          rx_state_nxt = USDP_START;
      end
      USDP_START: begin
        if (rx_cnt_r == HALF) begin
          rx_cnt_nxt = '0;
          rx_bit_nxt = 3'd0;
          rx_state_nxt = rx_in ? USDP_IDLE : USDP_DATA;
        end
      end
      USDP_DATA: begin
        if (rx_cnt_r == LAST) begin
          rx_shift_nxt = {rx_in, rx_shift_r[7:1]};
          rx_bit_nxt = rx_bit_r + 1'b1;
          if (rx_bit_r == 3'd7)
            rx_state_nxt = USDP_STOP;
        end
      end
      default: begin
        if (rx_cnt_r == LAST) begin
          rx_arrive = rx_in;
          rx_state_nxt = USDP_IDLE;
        end
      end
    endcase
    // receive buffer: capacity one when fifo is off
    rx_push = 1'b0;
    rx_over = 1'b0;
    rx_mem_idx = rx_wp_r;
    if (rx_arrive) begin
      if (fifo_en ? (rx_count_r != FULL || rx_pop)
          : (rx_count_r == '0 || rx_pop)) begin
        rx_push = 1'b1;
      end else if (!fifo_en) begin
        rx_over = 1'b1;
        rx_mem_idx = rx_rp_r;
      end
    end
    rx_wp_nxt = rx_push ? rx_wp_r + 1'b1 : rx_wp_r;
    rx_rp_nxt = rx_pop ? rx_rp_r + 1'b1 : rx_rp_r;
    rx_count_nxt = rx_count_r + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    // transmit buffer
    tx_pop = tx_state_r == USDP_IDLE && tx_count_r != '0;
    tx_push = 1'b0;
    tx_over = 1'b0;
    tx_mem_idx = tx_wp_r;
    if (tx_wr) begin
      if (fifo_en ? (tx_count_r != FULL || tx_pop)
          : (tx_count_r == '0 || tx_pop)) begin
        tx_push = 1'b1;
      end else if (!fifo_en) begin
        tx_over = 1'b1;
        tx_mem_idx = tx_rp_r;
      end
    end
    tx_wp_nxt = tx_push ? tx_wp_r + 1'b1 : tx_wp_r;
    tx_rp_nxt = tx_pop ? tx_rp_r + 1'b1 : tx_rp_r;
    tx_count_nxt = tx_count_r + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
    // transmitter
    tx_state_nxt = tx_state_r;
    tx_cnt_nxt = tx_cnt_r + 1'b1;
    tx_bit_nxt = tx_bit_r;
    tx_shift_nxt = tx_shift_r;
    tx_line_nxt = tx_line_r;
    case (tx_state_r)
      USDP_IDLE: begin
        tx_cnt_nxt = '0;
        if (tx_pop) begin
          tx_shift_nxt = tx_head;
          tx_line_nxt = 1'b0;
          tx_state_nxt = USDP_START;
        end
      end
      USDP_START: begin
        if (tx_cnt_r == LAST) begin
          tx_line_nxt = tx_shift_r[0];
          tx_shift_nxt = {1'b0, tx_shift_r[7:1]};
          tx_bit_nxt = 3'd0;
          tx_state_nxt = USDP_DATA;
        end
      end
      USDP_DATA: begin
        if (tx_cnt_r == LAST) begin
          tx_line_nxt = tx_bit_r == 3'd7 ? 1'b1 : tx_shift_r[0];
          tx_shift_nxt = {1'b0, tx_shift_r[7:1]};
          tx_bit_nxt = tx_bit_r + 1'b1;
          if (tx_bit_r == 3'd7)
            tx_state_nxt = USDP_STOP;
        end
      end
      default: begin
        if (tx_cnt_r == LAST)
          tx_state_nxt = USDP_IDLE;
      end
    endcase
    // sticky flags: a read clears, a new event in the same cycle wins
    oe_nxt = oe_r;
    if (rd_take && ARADDR == `USDP_LINE_STAT_ADDR)
      oe_nxt = 1'b0;
    if (rx_over || (rx_arrive && !rx_push))
      oe_nxt = 1'b1;
    isr_nxt = (rd_take && ARADDR == `USDP_ISR_ADDR) ? 3'b000 : isr_r;
    isr_nxt[`USDP_IRQ_RX] = isr_nxt[`USDP_IRQ_RX] | rx_push;
    isr_nxt[`USDP_IRQ_OE] = isr_nxt[`USDP_IRQ_OE] | (rx_arrive && !rx_push);
    isr_nxt[`USDP_IRQ_TX_EMPTY] = isr_nxt[`USDP_IRQ_TX_EMPTY]
      | (tx_count_nxt == '0 && !tx_empty);
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 32'h0000_0000;
      w_hold_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `USDP_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `USDP_RESP_OKAY;
      rd_shadow_r <= 1'b0;
      ctrl_r <= 2'b00;
      imr_r <= 3'b000;
      isr_r <= 3'b000;
      oe_r <= 1'b0;
      rx_state_r <= USDP_IDLE;
      rx_cnt_r <= '0;
      rx_bit_r <= 3'd0;
      rx_shift_r <= 8'h00;
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      rx_count_r <= '0;
      tx_state_r <= USDP_IDLE;
      tx_cnt_r <= '0;
      tx_bit_r <= 3'd0;
      tx_shift_r <= 8'h00;
      tx_line_r <= 1'b1;
      tx_wp_r <= '0;
      tx_rp_r <= '0;
      tx_count_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        rx_mem[i] <= `USDP_DATA_RESET;
        tx_mem[i] <= `USDP_DATA_RESET;
      end
    end else begin
      aw_hold_r <= aw_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_hold_r <= w_hold_nxt;
      w_data_r <= w_data_nxt;
      w_strb0_r <= w_strb0_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      rd_shadow_r <= rd_shadow_nxt;
      ctrl_r <= ctrl_nxt;
      imr_r <= imr_nxt;
      isr_r <= isr_nxt;
      oe_r <= oe_nxt;
      rx_state_r <= rx_state_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_shift_r <= rx_shift_nxt;
      rx_wp_r <= rx_wp_nxt;
      rx_rp_r <= rx_rp_nxt;
      rx_count_r <= rx_count_nxt;
      tx_state_r <= tx_state_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_shift_r <= tx_shift_nxt;
      tx_line_r <= tx_line_nxt;
      tx_wp_r <= tx_wp_nxt;
      tx_rp_r <= tx_rp_nxt;
      tx_count_r <= tx_count_nxt;
      if (rx_push || rx_over)
        rx_mem[rx_mem_idx] <= rx_shift_r;
      if (tx_push || tx_over)
        tx_mem[tx_mem_idx] <= w_data_r[7:0];
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  a_shadow_read_head: assert property (
    rd_take && is_shadow(ARADDR) |=> RVALID && RDATA[7:0] == $past(rx_head))
    else $error("shadow read did not return the receive head");
  a_reserved_zero: assert property (
    RVALID && rd_shadow_r |-> RDATA[31:8] == 24'h000000)
    else $error("reserved bits of shadow read not zero");
  a_alias_write: assert property (
    do_write && is_shadow(aw_addr_r) && w_strb0_r && tx_empty && !fifo_en
    && tx_state_r == USDP_IDLE |=> ##1 tx_state_r == USDP_START)
    else $error("alias write did not start transmission");
  a_rx_pop_head: assert property (
    fifo_en && rx_pop && !rx_push |=> rx_count_r == $past(rx_count_r) - 1'b1)
    else $error("fifo read did not consume the head");
  a_rx_full_drop: assert property (
    fifo_en && rx_count_r == FULL && rx_arrive && !rx_pop
    |=> rx_count_r == FULL && oe_r && rx_head == $past(rx_head))
    else $error("full receive fifo not preserved with overrun");
  a_rx_overwrite: assert property (
    !fifo_en && rx_count_r == 1 && rx_arrive && !rx_pop
    |=> oe_r && rx_count_r == 1 && rx_head == $past(rx_shift_r))
    else $error("non-fifo arrival did not overwrite with overrun");
  a_ir_rx_source: assert property (
    rx_state_r == USDP_IDLE && ir_mode && !SIR_IN |=> rx_state_r == USDP_START)
    else $error("infrared input did not start reception");
  a_ir_tx_pins: assert property (
    tx_state_r == USDP_START |-> (ir_mode ? !SIR_OUT_N && SOUT : !SOUT))
    else $error("start bit on the wrong output");
  a_holding_clear: assert property (
    !fifo_en && tx_empty && tx_wr
    |=> !tx_empty && tx_head == $past(w_data_r[7:0]))
    else $error("write did not clear holding-empty");
  a_tx_overwrite: assert property (
    !fifo_en && tx_count_r == 1 && tx_wr && !tx_pop
    |=> tx_count_r == 1 && tx_head == $past(w_data_r[7:0]))
    else $error("pending transmit byte not overwritten");
  a_tx_fill_depth: assert property (
    fifo_en && tx_wr && tx_count_r < FULL && !tx_pop
    |=> tx_count_r == $past(tx_count_r) + 1'b1)
    else $error("transmit fifo did not accept a byte");
  a_tx_full_drop: assert property (
    fifo_en && tx_wr && tx_count_r == FULL && !tx_pop |=> tx_count_r == FULL)
    else $error("write to full transmit fifo not dropped");
  a_data_reset: assert property (
    $fell(RST) |-> rx_head == `USDP_DATA_RESET && tx_head == `USDP_DATA_RESET)
    else $error("data field not zero after reset");

  c_rx_overrun: cover property (rx_arrive && !rx_push);
  c_tx_full: cover property (fifo_en && tx_count_r == FULL);
  c_shadow_read: cover property (rx_pop ##1 RVALID);
  c_ir_send: cover property (ir_mode && tx_state_r == USDP_STOP);
endmodule

// *** hw/usdp_map.svh ***
// address map, field positions, reset values and timing counts
`ifndef USDP_MAP_SVH
`define USDP_MAP_SVH
`define USDP_SHADOW_BASE 32'h5000_1130
`define USDP_SHADOW_LAST 32'h5000_116c
`define USDP_DATA10_ADDR 32'h5000_1158
`define USDP_CTRL_ADDR 32'h5000_1180
`define USDP_LINE_STAT_ADDR 32'h5000_1184
`define USDP_ISR_ADDR 32'h5000_1188
`define USDP_IMR_ADDR 32'h5000_118c
`define USDP_DATA_RESET 8'h00
`define USDP_CTRL_FIFO_EN 0
`define USDP_CTRL_IR_MODE 1
`define USDP_STAT_RX_READY 0
`define USDP_STAT_OVERRUN 1
`define USDP_STAT_TX_EMPTY 5
`define USDP_IRQ_RX 0
`define USDP_IRQ_OE 1
`define USDP_IRQ_TX_EMPTY 2
`define USDP_CLKS_PER_BIT 16
`define USDP_FIFO_DEPTH 16
`define USDP_RESP_OKAY 2'b00
`define USDP_RESP_SLVERR 2'b10
`endif

// *** hw/usdp_pkg.sv ***
// types shared by the shadow data port
package usdp_pkg;
  typedef enum logic [1:0] {
    USDP_IDLE = 2'b00,
    USDP_START = 2'b01,
    USDP_DATA = 2'b11,
    USDP_STOP = 2'b10
  } usdp_state_type;
endpackage

// *** bench/usdp_link_model.sv ***
// serial link partner: sends frames in, collects frames from the uart
`timescale 1ns/10ps
module usdp_link_model #(
  parameter int CPB = 4
) (
  input wire logic mclk,
  input wire logic sout,
  input wire logic sir_out_n,
  output logic sin,
  output logic sir_in
);
  // each entry: infrared flag above the received byte
  logic [8:0] got_q[$];
  wire line_w = sout & sir_out_n;
  initial begin
    sin = 1'b1;
    sir_in = 1'b1;
  end
  // start low, eight bits lsb first, stop high, then an idle bit time
  task automatic send_byte(input logic [7:0] b, input logic ir);
    logic [9:0] f;
    int i;
    f = {1'b1, b, 1'b0};
    for (i = 0; i < 10; i++) begin
      @(posedge mclk);
      if (ir) sir_in <= f[i];
      else sin <= f[i];
      repeat (CPB - 1) @(posedge mclk);
    end
    repeat (CPB) @(posedge mclk);
  endtask
  // sampled on the falling edge, clear of the uart's own updates
  initial begin : rx_watch
    logic [7:0] b;
    logic ir;
    int i;
    forever begin
      @(negedge mclk);
      if (line_w === 1'b0) begin
        ir = !sir_out_n;
        repeat (CPB / 2) @(negedge mclk);
        for (i = 0; i < 8; i++) begin
          repeat (CPB) @(negedge mclk);
          b[i] = line_w;
        end
        repeat (CPB) @(negedge mclk);
        got_q.push_back({ir, b});
      end
    end
  end
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the shadow data port
`timescale 1ns/10ps
`include "usdp_map.svh"
module testbench;
  localparam int DEP = 4;
  localparam int CPB = 4;
  logic MCLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic SOUT, SIR_OUT_N, IRQ, SIN, SIR_IN;
  logic [31:0] AWADDR, WDATA, ARADDR, RDATA, rd;
  logic [3:0] WSTRB, wr_strb;
  logic [1:0] BRESP, RRESP, rsp, wr_exp;
  int err_count, num_checks, i;
  usdp_uart #(.DEPTH(DEP), .CLKS_PER_BIT(CPB)) dut_u (
    .MCLK(MCLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .SIN(SIN),
    .SIR_IN(SIR_IN), .SOUT(SOUT), .SIR_OUT_N(SIR_OUT_N), .IRQ(IRQ)
  );
  usdp_link_model #(.CPB(CPB)) link_u (
    .mclk(MCLK), .sout(SOUT), .sir_out_n(SIR_OUT_N), .sin(SIN),
    .sir_in(SIR_IN)
  );
  initial begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end
  task automatic stop_test();
    $display("mismatches %0d of %0d checks", err_count, num_checks);
    if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic hang(input string nm);
    err_count++;
    $display("CHECK FAILED %s expected answer seen none", nm);
    stop_test();
  endtask
  // entered just after a rising edge; handshakes judged on the low phase
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
    int k;
    logic aw, w, b;
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= wr_strb;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(negedge MCLK);
      aw = AWVALID && AWREADY;
      w = WVALID && WREADY;
      b = BVALID;
      rsp = BRESP;
      @(posedge MCLK);
      if (aw) AWVALID <= 1'b0;
      if (w) WVALID <= 1'b0;
      if (b) break;
    end
    BREADY <= 1'b0;
    @(posedge MCLK);
    if (k == 100) hang("write response");
    check("write resp", {30'h0, wr_exp}, {30'h0, rsp});
  endtask
  task automatic axi_read(input logic [31:0] a);
    int k;
    logic ar, r;
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(negedge MCLK);
      ar = ARVALID && ARREADY;
      r = RVALID;
      rd = RDATA;
      rsp = RRESP;
      @(posedge MCLK);
      if (ar) ARVALID <= 1'b0;
      if (r) break;
    end
    RREADY <= 1'b0;
    @(posedge MCLK);
    if (k == 100) hang("read response");
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp,
                        input string nm);
    axi_read(a);
    check({nm, " resp"}, {30'h0, `USDP_RESP_OKAY}, {30'h0, rsp});
    check(nm, exp, rd);
  endtask
  task automatic irq_chk(input logic exp);
    @(negedge MCLK);
    check("irq", {31'h0, exp}, {31'h0, IRQ});
    @(posedge MCLK);
  endtask
  task automatic wait_tx(input int n);
    int k;
    for (k = 0; k < 4000; k++) begin
      if (link_u.got_q.size() >= n) break;
      @(posedge MCLK);
    end
    if (k == 4000) hang("serial frame");
    repeat (12 * CPB) @(posedge MCLK);
    check("frame count", n, link_u.got_q.size());
  endtask
  initial begin
    RST = 1'b1;
    AWVALID = 1'b0;
    WVALID = 1'b0;
    BREADY = 1'b0;
    ARVALID = 1'b0;
    RREADY = 1'b0;
    AWADDR = 32'h0;
    WDATA = 32'h0;
    WSTRB = 4'h0;
    ARADDR = 32'h0;
    wr_strb = 4'hf;
    wr_exp = `USDP_RESP_OKAY;
    err_count = 0;
    num_checks = 0;
    repeat (20) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    rd_chk(`USDP_DATA10_ADDR, 32'h0, "data at reset");
    rd_chk(`USDP_LINE_STAT_ADDR, 32'h20, "status at reset");
    axi_read(32'h5000_1100);
    check("unmapped resp", {30'h0, `USDP_RESP_SLVERR}, {30'h0, rsp});
    check("unmapped data", 32'h0, rd);
    wr_exp = `USDP_RESP_SLVERR;
    axi_write(32'h5000_1190, 32'h3);
    wr_exp = `USDP_RESP_OKAY;
    axi_write(`USDP_LINE_STAT_ADDR, 32'h0);
    axi_read(`USDP_ISR_ADDR);
    link_u.send_byte(8'ha5, 1'b0);
    irq_chk(1'b0);
    axi_write(`USDP_IMR_ADDR, 32'h1);
    irq_chk(1'b1);
    rd_chk(`USDP_IMR_ADDR, 32'h1, "mask readback");
    rd_chk(`USDP_ISR_ADDR, 32'h1, "event status");
    irq_chk(1'b0);
    rd_chk(`USDP_LINE_STAT_ADDR, 32'h21, "data ready");
    rd_chk(`USDP_SHADOW_BASE, 32'ha5, "rx byte");
    rd_chk(`USDP_LINE_STAT_ADDR, 32'h20, "rx consumed");
    link_u.send_byte(8'h11, 1'b0);
    link_u.send_byte(8'h22, 1'b0);
    rd_chk(`USDP_LINE_STAT_ADDR, 32'h23, "overrun single");
    rd_chk(`USDP_ISR_ADDR, 32'h3, "overrun event");
    rd_chk(`USDP_SHADOW_LAST, 32'h22, "newest kept");
    axi_write(`USDP_CTRL_ADDR, 32'h2);
    wr_strb = 4'he;
    axi_write(`USDP_CTRL_ADDR, 32'h1);
    wr_strb = 4'hf;
    rd_chk(`USDP_CTRL_ADDR, 32'h2, "ctrl strobe");
    link_u.send_byte(8'h6c, 1'b1);
    rd_chk(`USDP_DATA10_ADDR, 32'h6c, "infrared rx");
    axi_write(`USDP_DATA10_ADDR, 32'hffff_ff3c);
    wait_tx(1);
    check("infrared tx", 32'h13c, {23'h0, link_u.got_q[0]});
    rd_chk(`USDP_ISR_ADDR, 32'h5, "tx empty event");
    axi_write(`USDP_CTRL_ADDR, 32'h0);
    link_u.got_q.delete();
    axi_write(`USDP_DATA10_ADDR, 32'ha1);
    axi_write(`USDP_DATA10_ADDR, 32'hb2);
    rd_chk(`USDP_LINE_STAT_ADDR, 32'h0, "holding full");
    axi_write(`USDP_DATA10_ADDR, 32'hc3);
    wait_tx(2);
    check("serial tx 0", 32'ha1, {23'h0, link_u.got_q[0]});
    check("serial tx 1", 32'hc3, {23'h0, link_u.got_q[1]});
    rd_chk(`USDP_LINE_STAT_ADDR, 32'h20, "holding empty");
    axi_write(`USDP_CTRL_ADDR, 32'h1);
    for (i = 0; i <= DEP; i++) link_u.send_byte(8'h40 + i[7:0], 1'b0);
    rd_chk(`USDP_LINE_STAT_ADDR, 32'h23, "overrun fifo");
    for (i = 0; i < DEP; i++) begin
      rd_chk(`USDP_SHADOW_BASE + 4 * i, 32'h40 + i, "fifo head");
    end
    rd_chk(`USDP_LINE_STAT_ADDR, 32'h20, "fifo drained");
    link_u.got_q.delete();
    for (i = 0; i < DEP + 2; i++) begin
      axi_write(`USDP_DATA10_ADDR, 32'h80 + i);
    end
    rd_chk(`USDP_LINE_STAT_ADDR, 32'h0, "tx fifo busy");
    wait_tx(DEP + 1);
    for (i = 0; i <= DEP; i++) begin
      check("fifo tx", 32'h80 + i, {23'h0, link_u.got_q[i]});
    end
    stop_test();
  end
endmodule
